// ===== core/hcrm_map.svh
// Purpose: offsets, field positions, reset values and timing counts of
//          the holdover clock reference monitor.
// Assumes: 125 MHz system clock; APB register slave with 32-bit data.
// Notes:   definitions only; included by bare name.
`ifndef HCRM_MAP_SVH
`define HCRM_MAP_SVH

// ************************************************************
// register offsets
// ************************************************************
`define HCRM_REG_CTRL 8'h00
`define HCRM_REG_STATUS 8'h04
`define HCRM_REG_IRQ_STATUS 8'h08
`define HCRM_REG_IRQ_ENABLE 8'h0c
`define HCRM_REG_IRQ_CLEAR 8'h10

// ************************************************************
// fields and reset values
// ************************************************************
`define HCRM_CTRL_HOLD_BIT 0
`define HCRM_CTRL_TOL_LSB 1
`define HCRM_CTRL_TOL_MSB 3
`define HCRM_CTRL_RESET 4'h2
`define HCRM_ST_VALID_BIT 0
`define HCRM_ST_BYPASS_BIT 1
`define HCRM_ST_MON_LSB 2
`define HCRM_ST_OUTMODE_LSB 4
`define HCRM_ST_CAP_LSB 8
`define HCRM_ST_COUNT_LSB 16
`define HCRM_ST_SEL_LSB 24
`define HCRM_IRQ_FAIL_BIT 0
`define HCRM_IRQ_RESTORE_BIT 1
`define HCRM_IRQ_LIMIT_BIT 2
`define HCRM_IRQ_RESET 3'h0
`define HCRM_CAP_MID 8'h80
`define HCRM_CAP_MIN 8'h00
`define HCRM_CAP_MAX 8'hff
`define HCRM_PULL_PPM 300
`define HCRM_BYPASS_CODE 4'h0

// ************************************************************
// timing
// ************************************************************
`define HCRM_WIN_SHIFT 4
`define HCRM_CLK_PERIOD_NS 8
`define HCRM_FLAG_EXTRA_NS 25
`define HCRM_FLAG_ASSERT_XTAL 8'h02
`define HCRM_FLAG_DEASSERT_XTAL 4'hc
`define HCRM_FLAG_DEASSERT_EXTRA_CYC \
  ((`HCRM_FLAG_EXTRA_NS + `HCRM_CLK_PERIOD_NS - 1) / `HCRM_CLK_PERIOD_NS)

`endif

// ===== core/hcrm_pkg.sv
// Purpose: types of the holdover clock reference monitor.
// Assumes: constants live in hcrm_map.svh.
// Notes:   nothing here is imported; users write hcrm_pkg::name.
`default_nettype none
package hcrm_pkg;

  typedef enum logic [1:0] {mon_hold, mon_qualify, mon_locked} hcrm_mon_e;

  typedef enum logic [2:0] {
    out_div4, out_div2, out_x1, out_x2, out_x4, out_x8
  } hcrm_out_mode_e;

  typedef struct packed {
    logic [3:0] num;
    logic [3:0] den;
    hcrm_out_mode_e out_mode;
  } hcrm_ratio_s;

  typedef struct packed {
    logic [2:0] prev;
    logic [2:0] rise;
  } hcrm_edge_s;

  typedef struct packed {
    hcrm_mon_e mon;
    logic valid;
    logic [7:0] cap_code;
    logic [7:0] win_cnt;
    logic [7:0] ref_cnt;
    logic [7:0] miss_cnt;
    logic [7:0] last_cnt;
    logic win_good;
    logic phase_lead;
    logic sel_q;
    logic [3:0] good_cnt;
    logic [2:0] dly_cnt;
    logic out_clk;
    logic xtal_drive;
    logic [3:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [31:0] prdata;
  } hcrm_state_s;

endpackage
`default_nettype wire

// ===== core/hcrm_edge_detect.sv
// Purpose: registered rising-edge pulses for three sampled clock levels.
// Assumes: inputs are synchronous to clk.
// Notes:   one cycle of latency on every pulse, the same for all bits.
`timescale 1ns/1ps
`default_nettype none
module hcrm_edge_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] level_in,
  output logic [2:0] rise
);
  hcrm_pkg::hcrm_edge_s st_reg;
  hcrm_pkg::hcrm_edge_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.prev = level_in;
    st_next.rise = level_in & ~st_reg.prev;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rise = st_reg.rise;
endmodule
`default_nettype wire

// ===== core/hcrm_monitor.sv
// Purpose: reference selection, validity monitor, crystal tuning code,
//          output banks and APB register slave with interrupt.
// Assumes: all pins synchronous to clk; crystal and references far
//          slower than clk so every edge is seen.
// Notes:   edge counts stand in for the analog loop's comparison.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "hcrm_map.svh"
module hcrm_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ref_clock_in_a,
  input wire logic ref_clock_in_b,
  input wire logic reference_select,
  input wire logic [3:0] freq_select,
  input wire logic crystal_in,
  input wire logic feedback_in,
  output logic crystal_out,
  output logic [3:0] bank_a_clock_out,
  output logic [3:0] bank_b_clock_out,
  output logic ref_valid,
  output logic [7:0] cap_array_code,
  output logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ************************************************************
  // ratio decode
  // ************************************************************
  function automatic hcrm_pkg::hcrm_ratio_s ratio_of(input logic [3:0] s);
    hcrm_pkg::hcrm_ratio_s r;
    r = '{num: 4'h1, den: 4'h1, out_mode: hcrm_pkg::out_x1};
    case (s)
      4'h8: r = '{num: 4'h2, den: 4'h1, out_mode: hcrm_pkg::out_div2};
      4'he: r = '{num: 4'h6, den: 4'h1, out_mode: hcrm_pkg::out_div2};
      4'h5: r = '{num: 4'h4, den: 4'h5, out_mode: hcrm_pkg::out_div4};
      4'hb: r = '{num: 4'h3, den: 4'h1, out_mode: hcrm_pkg::out_div4};
      4'h3: r = '{num: 4'h1, den: 4'h3, out_mode: hcrm_pkg::out_x1};
      4'h9: r = '{num: 4'h1, den: 4'h1, out_mode: hcrm_pkg::out_x1};
      4'hf: r = '{num: 4'h4, den: 4'h1, out_mode: hcrm_pkg::out_x1};
      4'hc: r = '{num: 4'h8, den: 4'h1, out_mode: hcrm_pkg::out_x1};
      4'h1: r = '{num: 4'h1, den: 4'h8, out_mode: hcrm_pkg::out_x2};
      4'h6: r = '{num: 4'h1, den: 4'h2, out_mode: hcrm_pkg::out_x2};
      4'hd: r = '{num: 4'h2, den: 4'h1, out_mode: hcrm_pkg::out_x2};
      4'h4: r = '{num: 4'h1, den: 4'h2, out_mode: hcrm_pkg::out_x4};
      4'ha: r = '{num: 4'h3, den: 4'h2, out_mode: hcrm_pkg::out_x4};
      4'h2: r = '{num: 4'h1, den: 4'h6, out_mode: hcrm_pkg::out_x8};
      4'h7: r = '{num: 4'h3, den: 4'h4, out_mode: hcrm_pkg::out_x8};
      default: r = '{num: 4'h1, den: 4'h1, out_mode: hcrm_pkg::out_x1};
    endcase
    return r;
  endfunction

  // crystal periods without a reference edge before the flag falls;
  // a reference slower than the crystal needs its own period plus one
  function automatic logic [7:0] miss_limit(input hcrm_pkg::hcrm_ratio_s r);
    logic [7:0] per;
    per = 8'((r.den + r.num - 4'h1) / r.num);
    if (r.num >= r.den) begin
      return `HCRM_FLAG_ASSERT_XTAL;
    end
    return per + 8'h01;
  endfunction

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction

  function automatic logic [7:0] abs_diff(input logic [7:0] a,
                                          input logic [7:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // ************************************************************
  // edges and selection
  // ************************************************************
  hcrm_pkg::hcrm_state_s st_reg;
  hcrm_pkg::hcrm_state_s st_next;
  hcrm_pkg::hcrm_ratio_s ratio;
  logic ref_sel;
  logic ref_rise;
  logic xtal_rise;
  logic fb_rise;
  logic bypass;
  logic [7:0] win_len;
  logic [7:0] expect_cnt;
  logic [7:0] ref_cnt_now;
  logic missing;
  logic win_end;
  logic win_ok;
  logic ev_fail;
  logic ev_restore;
  logic ev_limit;
  logic acc;
  logic wr;
  logic mapped;

  assign ref_sel = reference_select ? ref_clock_in_a :
                   ref_clock_in_b;
  assign bypass = (freq_select == `HCRM_BYPASS_CODE);
  assign ratio = ratio_of(freq_select);
  assign win_len = 8'(ratio.den) << `HCRM_WIN_SHIFT;
  assign expect_cnt = 8'(ratio.num) << `HCRM_WIN_SHIFT;

  hcrm_edge_detect u_edges (
    .clk(clk),
    .rst_n(rst_n),
    .level_in({feedback_in, crystal_in, ref_sel}),
    .rise({fb_rise, xtal_rise, ref_rise})
  );

  // ************************************************************
  // apb decode
  // ************************************************************
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign mapped = (paddr == `HCRM_REG_CTRL) || (paddr == `HCRM_REG_STATUS) ||
                  (paddr == `HCRM_REG_IRQ_STATUS) ||
                  (paddr == `HCRM_REG_IRQ_ENABLE) ||
                  (paddr == `HCRM_REG_IRQ_CLEAR);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    ev_fail = 1'b0;
    ev_restore = 1'b0;
    ev_limit = 1'b0;
    ref_cnt_now = st_reg.ref_cnt;
    if (ref_rise) begin
      ref_cnt_now = sat_inc(st_reg.ref_cnt);
    end
    missing = (st_reg.miss_cnt >= miss_limit(ratio));
    win_end = xtal_rise && (sat_inc(st_reg.win_cnt) >= win_len);
    win_ok = abs_diff(ref_cnt_now, expect_cnt) <=
             8'(st_reg.ctrl[`HCRM_CTRL_TOL_MSB:`HCRM_CTRL_TOL_LSB]);

    // phase sense: feedback already high at a reference edge means
    // the outputs lead the reference
    if (ref_rise) begin
      st_next.miss_cnt = 8'h00;
      st_next.phase_lead = feedback_in || fb_rise;
    end else if (xtal_rise) begin
      st_next.miss_cnt = sat_inc(st_reg.miss_cnt);
    end
    st_next.ref_cnt = ref_cnt_now;

    // window of crystal periods compared with reference edges
    if (xtal_rise) begin
      st_next.win_cnt = sat_inc(st_reg.win_cnt);
    end
    if (win_end) begin
      st_next.win_cnt = 8'h00;
      st_next.ref_cnt = 8'h00;
      st_next.last_cnt = ref_cnt_now;
      st_next.win_good = win_ok;
    end
    // a reference swap restarts measurement, never touches the crystal
    st_next.sel_q = reference_select;
    if (st_reg.sel_q != reference_select) begin
      st_next.win_cnt = 8'h00;
      st_next.ref_cnt = 8'h00;
      st_next.win_good = 1'b0;
    end

    // tuning runs only while locked, so a lost or out-of-range
    // reference leaves the last code in place
    if (win_end && st_reg.mon == hcrm_pkg::mon_locked && win_ok && !bypass &&
        !st_reg.ctrl[`HCRM_CTRL_HOLD_BIT]) begin
      if (ref_cnt_now > expect_cnt ||
          (ref_cnt_now == expect_cnt && !st_reg.phase_lead)) begin
        if (st_reg.cap_code != `HCRM_CAP_MIN) begin
          st_next.cap_code = st_reg.cap_code - 8'h01;
        end else begin
          ev_limit = 1'b1;
        end
      end else begin
        if (st_reg.cap_code != `HCRM_CAP_MAX) begin
          st_next.cap_code = st_reg.cap_code + 8'h01;
        end else begin
          ev_limit = 1'b1;
        end
      end
    end

    // ************************************************************
    // validity with hysteresis
    // ************************************************************
    case (st_reg.mon)
      hcrm_pkg::mon_locked: begin
        if (missing || (win_end && !win_ok && !bypass)) begin
          st_next.mon = hcrm_pkg::mon_hold;
          st_next.valid = 1'b0;
          ev_fail = 1'b1;
        end
      end
      hcrm_pkg::mon_hold: begin
        if (!missing && (bypass || st_reg.win_good)) begin
          st_next.mon = hcrm_pkg::mon_qualify;
          st_next.good_cnt = 4'h0;
          st_next.dly_cnt = 3'h0;
        end
      end
      hcrm_pkg::mon_qualify: begin
        if (missing || (win_end && !win_ok && !bypass)) begin
          st_next.mon = hcrm_pkg::mon_hold;
        end else if (st_reg.good_cnt < `HCRM_FLAG_DEASSERT_XTAL) begin
          if (xtal_rise) begin
            st_next.good_cnt = st_reg.good_cnt + 4'h1;
          end
        end else if (st_reg.dly_cnt < 3'(`HCRM_FLAG_DEASSERT_EXTRA_CYC)) begin
          st_next.dly_cnt = st_reg.dly_cnt + 3'h1;
        end else begin
          st_next.mon = hcrm_pkg::mon_locked;
          st_next.valid = 1'b1;
          ev_restore = 1'b1;
        end
      end
      default: begin
        st_next.mon = hcrm_pkg::mon_hold;
        st_next.valid = 1'b0;
      end
    endcase

    // ************************************************************
    // output path
    // ************************************************************
    // the crystal is the only source of the banks except in bypass
    st_next.out_clk = bypass ? ref_sel : crystal_in;
    st_next.xtal_drive = ~crystal_in;

    // ************************************************************
    // registers and interrupt
    // ************************************************************
    if (wr && paddr == `HCRM_REG_CTRL) begin
      st_next.ctrl = pwdata[3:0];
    end
    if (wr && paddr == `HCRM_REG_IRQ_ENABLE) begin
      st_next.irq_en = pwdata[2:0];
    end
    // a new event in the clearing cycle survives the clear
    st_next.irq_stat = st_reg.irq_stat;
    if (wr && paddr == `HCRM_REG_IRQ_CLEAR) begin
      st_next.irq_stat = st_reg.irq_stat & ~pwdata[2:0];
    end
    st_next.irq_stat[`HCRM_IRQ_FAIL_BIT] =
      st_next.irq_stat[`HCRM_IRQ_FAIL_BIT] | ev_fail;
    st_next.irq_stat[`HCRM_IRQ_RESTORE_BIT] =
      st_next.irq_stat[`HCRM_IRQ_RESTORE_BIT] | ev_restore;
    st_next.irq_stat[`HCRM_IRQ_LIMIT_BIT] =
      st_next.irq_stat[`HCRM_IRQ_LIMIT_BIT] | ev_limit;

    // read data is captured in the setup cycle so it stands from a flop
    if (psel && !penable) begin
      st_next.prdata = 32'h0;
      case (paddr)
        `HCRM_REG_CTRL: begin
          st_next.prdata[3:0] = st_reg.ctrl;
        end
        `HCRM_REG_STATUS: begin
          st_next.prdata[`HCRM_ST_VALID_BIT] = st_reg.valid;
          st_next.prdata[`HCRM_ST_BYPASS_BIT] = bypass;
          st_next.prdata[`HCRM_ST_MON_LSB +: 2] = st_reg.mon;
          st_next.prdata[`HCRM_ST_OUTMODE_LSB +: 3] = ratio.out_mode;
          st_next.prdata[`HCRM_ST_CAP_LSB +: 8] = st_reg.cap_code;
          st_next.prdata[`HCRM_ST_COUNT_LSB +: 8] = st_reg.last_cnt;
          st_next.prdata[`HCRM_ST_SEL_LSB +: 4] = freq_select;
        end
        `HCRM_REG_IRQ_STATUS: begin
          st_next.prdata[2:0] = st_reg.irq_stat;
        end
        `HCRM_REG_IRQ_ENABLE: begin
          st_next.prdata[2:0] = st_reg.irq_en;
        end
        default: begin
          st_next.prdata = 32'h0;
        end
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.mon <= hcrm_pkg::mon_hold;
      st_reg.cap_code <= `HCRM_CAP_MID;
      st_reg.ctrl <= `HCRM_CTRL_RESET;
      st_reg.irq_stat <= `HCRM_IRQ_RESET;
      st_reg.irq_en <= `HCRM_IRQ_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // both banks of four come from the same flop, so they stay aligned
  assign bank_a_clock_out = {4{st_reg.out_clk}};
  assign bank_b_clock_out = {4{st_reg.out_clk}};
  assign crystal_out = st_reg.xtal_drive;
  assign ref_valid = st_reg.valid;
  assign cap_array_code = st_reg.cap_code;
  assign irq = |(st_reg.irq_stat & st_reg.irq_en);
  assign prdata = st_reg.prdata;

endmodule
`default_nettype wire

// ===== dv/hcrm_monitor_sva.sv
// Purpose: port-level checks of the reference monitor.
// Assumes: one clock domain; crystal and references slow against clk.
// Notes: bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module hcrm_monitor_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ref_clock_in_a,
  input wire logic ref_clock_in_b,
  input wire logic reference_select,
  input wire logic [3:0] freq_select,
  input wire logic crystal_in,
  input wire logic crystal_out,
  input wire logic [3:0] bank_a_clock_out,
  input wire logic [3:0] bank_b_clock_out,
  input wire logic ref_valid,
  input wire logic [7:0] cap_array_code,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr
);
  // ********************
  // helpers and properties
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic x_q, r_q, sel_ref, x_rise;
  logic [7:0] x_since, x_low;
  assign sel_ref = reference_select ? ref_clock_in_a : ref_clock_in_b;
  assign x_rise = crystal_in & ~x_q;
  // crystal rises since the last reference edge, and since the flag fell
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x_q <= 1'b0;
      r_q <= 1'b0;
      x_since <= 8'h00;
      x_low <= 8'h00;
    end else begin
      x_q <= crystal_in;
      r_q <= sel_ref;
      if (sel_ref && !r_q) begin
        x_since <= 8'h00;
      end else if (x_rise && x_since != 8'hff) begin
        x_since <= x_since + 8'h01;
      end
      if (ref_valid) begin
        x_low <= 8'h00;
      end else if (x_rise && x_low != 8'hff) begin
        x_low <= x_low + 8'h01;
      end
    end
  end
  sequence s_fall;
    ##[0:4] !ref_valid;
  endsequence
  property p_lost_ref;
    (x_since == 8'h02 && freq_select == 4'h9) |-> s_fall;
  endproperty
  a_lost_ref: assert property (p_lost_ref)
    else $error("flag high with reference missing");
  property p_rise_late;
    $rose(ref_valid) |-> x_low >= 8'h0c;
  endproperty
  a_rise_late: assert property (p_rise_late)
    else $error("flag rose too early");
  property p_xtal_path;
    $past(rst_n) && $past(freq_select) != 4'h0
      |-> bank_a_clock_out == {4{$past(crystal_in)}};
  endproperty
  a_xtal_path: assert property (p_xtal_path)
    else $error("bank not fed by crystal");
  property p_byp_a;
    $past(rst_n) && $past(freq_select) == 4'h0 && $past(reference_select)
      |-> bank_a_clock_out == {4{$past(ref_clock_in_a)}};
  endproperty
  a_byp_a: assert property (p_byp_a)
    else $error("bypass of input a wrong");
  property p_byp_b;
    $past(rst_n) && $past(freq_select) == 4'h0 && !$past(reference_select)
      |-> bank_a_clock_out == {4{$past(ref_clock_in_b)}};
  endproperty
  a_byp_b: assert property (p_byp_b)
    else $error("bypass of input b wrong");
  property p_banks;
    bank_b_clock_out == bank_a_clock_out;
  endproperty
  a_banks: assert property (p_banks)
    else $error("banks differ");
  property p_crystal_out;
    $past(rst_n) |-> crystal_out == !$past(crystal_in);
  endproperty
  a_crystal_out: assert property (p_crystal_out)
    else $error("crystal drive not inverse of crystal level");
  property p_freeze;
    $past(rst_n) && !ref_valid && $past(ref_valid) == 1'b0
      |-> $stable(cap_array_code);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("tuning moved without valid reference");
  property p_step;
    $past(rst_n) && $changed(cap_array_code)
      |-> cap_array_code == $past(cap_array_code) + 8'h01
       || cap_array_code == $past(cap_array_code) - 8'h01;
  endproperty
  a_step: assert property (p_step)
    else $error("tuning code jumped");
  property p_apb;
    psel && penable |-> pready && pslverr
      == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10});
  endproperty
  a_apb: assert property (p_apb)
    else $error("apb answer wrong");
endmodule
`default_nettype wire

// ===== dv/hcrm_sys_model.sv
// Purpose: system side: two references, crystal, feedback wire.
// Assumes: all sources far slower than clk.
// Notes: a stopped reference sits low, as its run input forces each toggle to low.
`timescale 1ns/1ps
`default_nettype none
module hcrm_sys_model (
  input wire logic clk,
  input wire logic run_a,
  input wire logic run_b,
  input wire logic [4:0] half_a,
  input wire logic [4:0] half_b,
  input wire logic loop_clk,
  output logic ref_clock_in_a,
  output logic ref_clock_in_b,
  output logic crystal_in,
  output logic feedback_in
);
  // ********************
  // clock sources
  // ********************
  logic [4:0] ca = 5'h00;
  logic [4:0] cb = 5'h00;
  logic [4:0] cx = 5'h00;
  initial begin
    ref_clock_in_a = 1'b0;
    ref_clock_in_b = 1'b0;
    crystal_in = 1'b0;
  end
  assign feedback_in = loop_clk;
  always @(posedge clk) begin
    ca <= (ca >= half_a - 5'h01) ? 5'h00 : ca + 5'h01;
    cb <= (cb >= half_b - 5'h01) ? 5'h00 : cb + 5'h01;
    cx <= (cx == 5'h07) ? 5'h00 : cx + 5'h01;
    if (ca >= half_a - 5'h01) begin
      ref_clock_in_a <= run_a & ~ref_clock_in_a;
    end
    if (cb >= half_b - 5'h01) begin
      ref_clock_in_b <= run_b & ~ref_clock_in_b;
    end
    if (cx == 5'h07) begin
      crystal_in <= ~crystal_in;
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Purpose: self-checking bench of the reference monitor.
// Assumes: crystal period of 16 clk; code 1001 gives equal rates.
// Notes: waits poll at the falling edge, where outputs have settled.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ********************
  // bench
  // ********************
  localparam int XP = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reference_select = 1'b1;
  logic [3:0] freq_select = 4'h9;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic run_a = 1'b1;
  logic run_b = 1'b1;
  logic [4:0] half_a = 5'h08;
  logic [4:0] half_b = 5'h06;
  logic ref_clock_in_a, ref_clock_in_b, crystal_in, feedback_in;
  logic crystal_out, ref_valid, irq, pready, pslverr, e;
  logic [3:0] bank_a_clock_out, bank_b_clock_out, seen;
  logic [7:0] cap_array_code, cap0;
  logic [31:0] prdata, q;
  int fail_count = 0;
  int tests_run = 0;
  int n;
  logic [2:0] mode_exp [16] = '{3'h0, 3'h3, 3'h5, 3'h2, 3'h4, 3'h0,
    3'h3, 3'h5, 3'h1, 3'h2, 3'h4, 3'h0, 3'h2, 3'h3, 3'h1, 3'h2};
  always #4 clk = ~clk;
  hcrm_sys_model sys (.clk, .run_a, .run_b, .half_a, .half_b,
    .loop_clk(bank_a_clock_out[0]), .ref_clock_in_a, .ref_clock_in_b,
    .crystal_in, .feedback_in);
  hcrm_monitor dut (.clk, .rst_n, .ref_clock_in_a, .ref_clock_in_b,
    .reference_select, .freq_select, .crystal_in, .feedback_in,
    .crystal_out, .bank_a_clock_out, .bank_b_clock_out, .ref_valid,
    .cap_array_code, .irq, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  task automatic chk(input string what, input logic [31:0] s,
                     input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, x, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", pready, 1'b1);
      tally_and_finish();
    end
  endtask
  // a bound that runs out ends the run
  task automatic wait_flag(input logic lvl, input int lim);
    n = 0;
    while (ref_valid !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (ref_valid !== lvl) begin
      chk("ref_valid wait", ref_valid, lvl);
      tally_and_finish();
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("ref_valid", ref_valid, 1'b0);
    chk("cap", cap_array_code, 8'h80);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", q, 32'h2);
    apb(1'b0, 8'h0c, 32'h0);
    chk("irq_enable", q, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("irq_clear", q, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped rd", {e, q[30:0]}, 32'h80000000);
    apb(1'b1, 8'h14, 32'hffffffff);
    chk("unmapped wr", e, 1'b1);
    $display("reset and map test done");
    for (int c = 1; c < 16; c++) begin
      freq_select <= c[3:0];
      repeat (4) @(posedge clk);
      apb(1'b0, 8'h04, 32'h0);
      chk("out mode", q[6:4], mode_exp[c]);
      chk("code", {q[27:24], q[1]}, {c[3:0], 1'b0});
    end
    $display("select code table done");
    freq_select <= 4'h0;
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h04, 32'h0);
    chk("bypass bit", q[1], 1'b1);
    run_b <= 1'b0;
    reference_select <= 1'b0;
    seen = 4'h0;
    repeat (24) @(posedge clk);
    repeat (40) begin
      @(negedge clk);
      seen = seen | bank_a_clock_out;
    end
    chk("bypass stopped b", seen, 4'h0);
    @(posedge clk);
    run_b <= 1'b1;
    reference_select <= 1'b1;
    freq_select <= 4'h9;
    $display("bypass test done");
    wait_flag(1'b1, 3000);
    apb(1'b0, 8'h08, 32'h0);
    chk("restore event", q[1], 1'b1);
    @(negedge clk);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, 8'h0c, 32'h2);
    @(negedge clk);
    chk("irq raised", irq, 1'b1);
    apb(1'b1, 8'h10, 32'h2);
    @(negedge clk);
    chk("irq cleared", irq, 1'b0);
    cap0 = cap_array_code;
    n = 0;
    while (cap_array_code === cap0 && n < 800) begin
      @(negedge clk);
      n++;
    end
    chk("tuning runs", cap_array_code !== cap0, 1'b1);
    // hold bit set, tolerance kept at one edge
    apb(1'b1, 8'h00, 32'h3);
    @(negedge clk);
    cap0 = cap_array_code;
    repeat (600) @(negedge clk);
    chk("hold cap", cap_array_code, cap0);
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b1, 8'h0c, 32'h1);
    run_a <= 1'b0;
    wait_flag(1'b0, 2 * XP + 4);
    @(negedge clk);
    chk("fail irq", irq, 1'b1);
    cap0 = cap_array_code;
    repeat (600) @(negedge clk);
    chk("frozen cap", cap_array_code, cap0);
    @(posedge clk);
    run_a <= 1'b1;
    wait_flag(1'b1, 3000);
    chk("deassert delay", n >= 12 * XP + 4, 1'b1);
    $display("fail and restore test done");
    @(posedge clk);
    half_a <= 5'h04;
    wait_flag(1'b0, 700);
    @(posedge clk);
    half_a <= 5'h08;
    wait_flag(1'b1, 3000);
    $display("capture range test done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("reset valid", ref_valid, 1'b0);
    chk("reset cap", cap_array_code, 8'h80);
    chk("reset irq", irq, 1'b0);
    chk("reset prdata", prdata, 32'h0);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule
bind hcrm_monitor hcrm_monitor_sva u_sva (.clk, .rst_n, .ref_clock_in_a,
  .ref_clock_in_b, .reference_select, .freq_select, .crystal_in, .crystal_out,
  .bank_a_clock_out, .bank_b_clock_out, .ref_valid, .cap_array_code,
  .psel, .penable, .paddr, .pready, .pslverr);
`default_nettype wire
